// [inc/rfc_pkg.sv]
package rfc_pkg;
  // ==========================================================
  // Register map: printed offsets are indices, byte address is index * 4.
  localparam logic [7:0] AUX_IDX  = 8'h0A;  // Auxiliary receive definition.
  localparam logic [7:0] EMD_IDX  = 8'h05;  // Noise frame suppression config.
  localparam logic [7:0] SST_IDX  = 8'h06;  // Subcarrier start limit.
  localparam logic [7:0] STAT_IDX = 8'h07;  // Read-only block status.

  // ==========================================================
  // Reset values and writable-bit masks.
  localparam logic [7:0] AUX_RST  = 8'h00;
  localparam logic [7:0] EMD_RST  = 8'h00;
  localparam logic [7:0] SST_RST  = 8'h00;
  localparam logic [7:0] AUX_MASK = 8'hBF;  // Bit 6 is reserved.
  localparam logic [7:0] EMD_MASK = 8'hCF;  // Bits 5:4 are reserved.
  localparam logic [7:0] SST_MASK = 8'h1F;  // Bits 7:5 are reserved.

  // ==========================================================
  // Field positions.
  localparam int AUX_CRC_SKIP   = 7;
  localparam int AUX_UID_HI     = 5;
  localparam int AUX_UID_LO     = 4;
  localparam int AUX_PHASE_SH   = 3;
  localparam int AUX_PULSE_SEL  = 2;
  localparam int AUX_FON_HI     = 1;
  localparam int AUX_FON_LO     = 0;
  localparam int EMD_EN         = 7;
  localparam int EMD_START_ERR  = 6;
  localparam int EMD_THLD_HI    = 3;
  localparam int EMD_THLD_LO    = 0;
  localparam int SST_HI         = 4;

  // ==========================================================
  // Encodings.
  localparam logic [3:0] UID_BYTES_4   = 4'h4;
  localparam logic [3:0] UID_BYTES_7   = 4'h7;
  localparam logic [3:0] UID_BYTES_RSV = 4'h0;
  localparam logic [1:0] SCF_CORR      = 2'h1;  // Stream subcarrier code with correlator.
  localparam logic [1:0] SCP_CORR      = 2'h3;  // Stream pulse count code with correlator.

  // ==========================================================
  // Timing: one quarter etu at 106 kb/s is 128/fc/4.
  localparam int CLK_PERIOD_NS   = 100;
  localparam int QUARTER_ETU_NS  = 2360;
  localparam int QUARTER_ETU_CYC = (QUARTER_ETU_NS / CLK_PERIOD_NS < 1) ? 1 : QUARTER_ETU_NS / CLK_PERIOD_NS;

  // Protocol currently framed by the receiver.
  typedef enum logic [2:0] {PROTO_ISO_A, PROTO_ISO_B, PROTO_NFC_F, PROTO_T1T, PROTO_STREAM} rfc_proto_t;
  // Receiver path selected.
  typedef enum logic [1:0] {RX_NONE, RX_CORRELATOR, RX_PULSE, RX_PULSE_COHERENT} rfc_rx_sel_t;
  // Subcarrier start timer states.
  typedef enum logic {SST_IDLE, SST_TIMING} rfc_sst_state_t;
endpackage

// [inc/rfc_sst_if.sv]
`timescale 1ns/1ps
// Signals between the register bank and the subcarrier start timer.
interface rfc_sst_if;
  logic       iso_b_106;       // ISO-B 106 kb/s framing active.
  logic       mask_receive_timer_expired;  // Mask receive timer expiry pulse.
  logic       subcarrier_det;  // Subcarrier detected pulse.
  logic [4:0] limit;           // Limit in quarter etu.
  logic       emd_en;          // Noise frame suppression on.
  logic       soft_err;        // Early subcarrier, soft error pulse.
  logic       restart;         // Early subcarrier, suppressed frame pulse.
  logic       window_open;     // Timer is measuring.
  modport ctrl  (output iso_b_106, mask_receive_timer_expired, subcarrier_det, limit, emd_en,
                 input soft_err, restart, window_open);
  modport timer (input iso_b_106, mask_receive_timer_expired, subcarrier_det, limit, emd_en,
                 output soft_err, restart, window_open);
endinterface

// [hw/rfc_sst_timer.sv]
`timescale 1ns/1ps
// Measures time from mask receive timer expiry to subcarrier detection.
module rfc_sst_timer
  import rfc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  rfc_sst_if.timer sst
);
  import rfc_pkg::*;

  rfc_sst_state_t state;  // Timer state.
  logic [7:0]     div;    // Quarter etu divider.
  logic [4:0]     count;  // Elapsed quarter etu.
  logic           tick;   // Quarter etu enable.
  logic           early;  // Subcarrier came before the limit.

  assign tick  = (div == 8'(QUARTER_ETU_CYC - 1));
  assign early = (state == SST_TIMING) && sst.subcarrier_det && (count < sst.limit);

  // ==========================================================
  // State and counters; the divider runs only while timing to save power.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= SST_IDLE;
      div   <= 8'h00;
      count <= 5'h00;
    end else begin
      unique case (state)
        SST_IDLE: begin
          // A zero limit can never be undercut, so no window opens.
          if (sst.mask_receive_timer_expired && sst.iso_b_106 && sst.limit != 5'h00) begin
            state <= SST_TIMING;
            div   <= 8'h00;
            count <= 5'h00;
          end
        end
        SST_TIMING: begin
          div <= tick ? 8'h00 : div + 8'h01;
          if (tick) begin
            count <= count + 5'h01;
          end
          // Close on detection, on reaching the limit, or when the protocol leaves.
          if (sst.subcarrier_det || !sst.iso_b_106 || (tick && count + 5'h01 >= sst.limit)) begin
            state <= SST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Event outputs; suppression turns a soft error into a restart.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sst.soft_err    <= 1'b0;
      sst.restart     <= 1'b0;
      sst.window_open <= 1'b0;
    end else begin
      sst.soft_err    <= early && !sst.emd_en;
      sst.restart     <= early && sst.emd_en;
      sst.window_open <= (state == SST_TIMING);
    end
  end

  early_soft_a: assert property (@(posedge clk) disable iff (reset)
    early && !sst.emd_en |=> sst.soft_err && !sst.restart)
    else $error("early subcarrier did not raise soft error");
  early_restart_a: assert property (@(posedge clk) disable iff (reset)
    early && sst.emd_en |=> sst.restart && !sst.soft_err)
    else $error("early subcarrier did not raise restart");
endmodule

// [hw/rfc_rx_framing.sv]
`timescale 1ns/1ps
//
// Functional notes
// - CRC skip bit clear checks every frame except REQA/WUPA answers and anticollision.
// - REQA, WUPA, anticollision always receive without CRC.
// - UID size: 00 four, 01 seven, 1x reserved.
// - Phase shift bit picks 0 or 90 degrees.
// - Pulse select 0 uses correlator reception.
// - Pulse select 1 uses pulse or coherent.
// - Suppression enable bit turns suppression on.
// - ISO-A 106k start needs clean first bits.
// - Short erroneous frames are suppressed as noise.
// - Start limit counts quarter etu, to 7.75.
// - Early subcarrier after mask timer: soft error.
//
module rfc_rx_framing
  import rfc_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output      logic               hreadyout,
  output      logic               hresp,
  output      logic [31:0]        hrdata,
  input  wire rfc_pkg::rfc_proto_t proto,
  input  wire logic [1:0]         stream_scf,
  input  wire logic [1:0]         stream_scp,
  input  wire logic               iso_a_106,
  input  wire logic               iso_b_106,
  input  wire logic               tx_reqa_wupa,
  input  wire logic               anticoll_active,
  input  wire logic               frame_done,
  input  wire logic [7:0]         frame_len,
  input  wire logic               frame_err,
  input  wire logic               crc_ok,
  input  wire logic               first_bits_done,
  input  wire logic               first_bits_err,
  input  wire logic               mask_receive_timer_expired,
  input  wire logic               subcarrier_det,
  output      logic               crc_check_en,
  output      logic [3:0]         uid_bytes,
  output      logic               phase_clock_shift,
  output      rfc_pkg::rfc_rx_sel_t rx_select,
  output      logic [1:0]         field_on_count,
  output      logic               frame_accept,
  output      logic               frame_suppress,
  output      logic               rx_error,
  output      logic               rx_start_irq,
  output      logic               soft_error_irq,
  output      logic               restart_irq
);
  import rfc_pkg::*;

  // ==========================================================
  // Declarations.
  logic [7:0]  auxiliary_rx_definition;         // Receive options.
  logic [7:0]  noise_frame_suppression_config;  // Suppression setup.
  logic [7:0]  subcarrier_start_limit;          // Start limit.
  logic        dphase;                          // Data phase pending.
  logic        dwrite;                          // Pending transfer writes.
  logic [7:0]  didx;                            // Pending register index.
  logic        dword;                           // Pending transfer is a word.
  logic        addr_ok;                         // Address phase accepted.
  logic        wr_en;                           // Write commits this cycle.
  logic [7:0]  rd_mux;                          // Read data selected.
  logic        auto_crc_skip;                   // REQA or WUPA frame pending.
  logic        last_suppressed;                 // Last frame was noise.
  logic        next_crc_check;                  // CRC check for the next frame.
  logic        suppress_now;                    // Frame qualifies as noise.
  rfc_rx_sel_t next_rx_select;                  // Receiver path decode.
  rfc_sst_if   sst ();                          // Start timer link.

  // ==========================================================
  // Bus slave: one wait state, so a word write always lands before any later read.
  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_en   = dphase && dwrite && dword;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dphase    <= 1'b0;
      dwrite    <= 1'b0;
      didx      <= 8'h00;
      dword     <= 1'b0;
      hreadyout <= 1'b1;
    end else if (addr_ok) begin
      // Address phase: remember it and stall for one cycle.
      dphase    <= 1'b1;
      dwrite    <= hwrite;
      didx      <= haddr[9:2];
      dword     <= (hsize == 3'h2);
      hreadyout <= 1'b0;
    end else if (dphase) begin
      // Data phase completes at the next edge.
      dphase    <= 1'b0;
      hreadyout <= 1'b1;
    end
  end

  // The response is always OKAY; held in a flop so the port is registered.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // ==========================================================
  // Read multiplexer; reserved bits and unmapped words read zero.
  always_comb begin
    rd_mux = 8'h00;
    if (didx == AUX_IDX) begin
      rd_mux = auxiliary_rx_definition & AUX_MASK;
    end else if (didx == EMD_IDX) begin
      rd_mux = noise_frame_suppression_config & EMD_MASK;
    end else if (didx == SST_IDX) begin
      rd_mux = subcarrier_start_limit & SST_MASK;
    end else if (didx == STAT_IDX) begin
      rd_mux = {5'h00, last_suppressed, auto_crc_skip, sst.window_open};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (dphase && !dwrite) begin
      hrdata <= {24'h00_0000, rd_mux};
    end
  end

  // ==========================================================
  // Register writes; reserved bits are masked so they never store.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      auxiliary_rx_definition        <= AUX_RST;
      noise_frame_suppression_config <= EMD_RST;
      subcarrier_start_limit         <= SST_RST;
    end else if (wr_en) begin
      if (didx == AUX_IDX) begin
        auxiliary_rx_definition <= hwdata[7:0] & AUX_MASK;
      end
      if (didx == EMD_IDX) begin
        noise_frame_suppression_config <= hwdata[7:0] & EMD_MASK;
      end
      if (didx == SST_IDX) begin
        subcarrier_start_limit <= hwdata[7:0] & SST_MASK;
      end
    end
  end

  // ==========================================================
  // REQA or WUPA sent: the answer comes without CRC. The flag lasts until
  // the frame ends; a new command in that same cycle wins over the clear.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      auto_crc_skip <= 1'b0;
    end else if (tx_reqa_wupa) begin
      auto_crc_skip <= 1'b1;
    end else if (frame_done) begin
      auto_crc_skip <= 1'b0;
    end
  end

  assign next_crc_check = !auxiliary_rx_definition[AUX_CRC_SKIP]
                          && !auto_crc_skip && !tx_reqa_wupa && !anticoll_active;

  // ==========================================================
  // Decodes of the auxiliary register, CRC check also gated by REQA/WUPA and anticollision, registered for clean outputs.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      crc_check_en      <= 1'b1;
      uid_bytes         <= UID_BYTES_4;
      phase_clock_shift <= 1'b0;
      field_on_count    <= 2'h0;
    end else begin
      crc_check_en <= next_crc_check;
      // Upper bit set is reserved and reports no valid size.
      if (auxiliary_rx_definition[AUX_UID_HI]) begin
        uid_bytes <= UID_BYTES_RSV;
      end else if (auxiliary_rx_definition[AUX_UID_LO]) begin
        uid_bytes <= UID_BYTES_7;
      end else begin
        uid_bytes <= UID_BYTES_4;
      end
      // Same select drives phase measurement and PM demodulation.
      phase_clock_shift <= auxiliary_rx_definition[AUX_PHASE_SH];
      // The field-on commands sample this value when issued.
      field_on_count <= auxiliary_rx_definition[AUX_FON_HI:AUX_FON_LO];
    end
  end

  // ==========================================================
  // Receiver path. Modes that cannot use a setting report RX_NONE so the
  // front end stays quiet rather than guessing.
  always_comb begin
    next_rx_select = RX_NONE;
    if (!auxiliary_rx_definition[AUX_PULSE_SEL]) begin
      unique case (proto)
        PROTO_ISO_A, PROTO_ISO_B, PROTO_NFC_F, PROTO_T1T: begin
          next_rx_select = RX_CORRELATOR;
        end
        PROTO_STREAM: begin
          if (stream_scf == SCF_CORR && stream_scp == SCP_CORR) begin
            next_rx_select = RX_CORRELATOR;
          end
        end
        default: begin
          next_rx_select = RX_NONE;
        end
      endcase
    end else begin
      unique case (proto)
        PROTO_ISO_B: begin
          next_rx_select = RX_PULSE_COHERENT;
        end
        PROTO_NFC_F, PROTO_STREAM: begin
          next_rx_select = RX_PULSE;
        end
        default: begin
          next_rx_select = RX_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_select <= RX_NONE;
    end else begin
      rx_select <= next_rx_select;
    end
  end

  // ==========================================================
  // End of frame: short frames with errors are dropped as disturbance.
  assign suppress_now = noise_frame_suppression_config[EMD_EN] && frame_err
                        && (frame_len < {4'h0, noise_frame_suppression_config[EMD_THLD_HI:EMD_THLD_LO]});

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frame_accept    <= 1'b0;
      frame_suppress  <= 1'b0;
      rx_error        <= 1'b0;
      last_suppressed <= 1'b0;
    end else begin
      frame_accept   <= 1'b0;
      frame_suppress <= 1'b0;
      rx_error       <= 1'b0;
      if (frame_done) begin
        if (suppress_now) begin
          frame_suppress  <= 1'b1;
          last_suppressed <= 1'b1;
        end else begin
          last_suppressed <= sst.restart;
          // A skipped CRC check leaves only framing errors to report.
          if (frame_err || (crc_check_en && !crc_ok)) begin
            rx_error <= 1'b1;
          end else begin
            frame_accept <= 1'b1;
          end
        end
      end else if (sst.restart) begin
        last_suppressed <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Reception start for ISO-A 106k depends on the first bits; other modes
  // start unconditionally.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_start_irq <= 1'b0;
    end else begin
      rx_start_irq <= first_bits_done
                      && (!iso_a_106 || !first_bits_err
                          || noise_frame_suppression_config[EMD_START_ERR]);
    end
  end

  // ==========================================================
  // Subcarrier start timer.
  assign sst.iso_b_106      = iso_b_106;
  assign sst.mask_receive_timer_expired = mask_receive_timer_expired;
  assign sst.subcarrier_det = subcarrier_det;
  assign sst.limit          = subcarrier_start_limit[SST_HI:0];
  assign sst.emd_en         = noise_frame_suppression_config[EMD_EN];
  assign soft_error_irq     = sst.soft_err;
  assign restart_irq        = sst.restart;

  rfc_sst_timer u_sst (
    .clk   (clk),
    .reset (reset),
    .sst   (sst.timer)
  );

  // ==========================================================
  // Checks.
  crc_skip_a: assert property (@(posedge clk) disable iff (reset)
    auxiliary_rx_definition[AUX_CRC_SKIP] |=> !crc_check_en)
    else $error("CRC check active while skip bit set");
  reqa_skip_a: assert property (@(posedge clk) disable iff (reset)
    tx_reqa_wupa |=> !crc_check_en ##1 !crc_check_en)
    else $error("CRC checked after REQA or WUPA");
  uid_size_a: assert property (@(posedge clk) disable iff (reset)
    auxiliary_rx_definition[5:4] == 2'h1 |=> uid_bytes == UID_BYTES_7)
    else $error("UID size decode wrong");
  phase_sel_a: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> phase_clock_shift == $past(auxiliary_rx_definition[AUX_PHASE_SH]))
    else $error("phase clock select not following register");
  corr_iso_a_a: assert property (@(posedge clk) disable iff (reset)
    !auxiliary_rx_definition[AUX_PULSE_SEL] && proto == PROTO_ISO_A |=> rx_select == RX_CORRELATOR)
    else $error("ISO-A not on correlator");
  pulse_iso_b_a: assert property (@(posedge clk) disable iff (reset)
    auxiliary_rx_definition[AUX_PULSE_SEL] && proto == PROTO_ISO_B |=> rx_select == RX_PULSE_COHERENT)
    else $error("ISO-B not on coherent pulse receiver");
  emd_off_a: assert property (@(posedge clk) disable iff (reset)
    !noise_frame_suppression_config[EMD_EN] |=> !frame_suppress)
    else $error("frame suppressed with suppression off");
  short_frame_a: assert property (@(posedge clk) disable iff (reset)
    frame_done && suppress_now |=> frame_suppress && !frame_accept && !rx_error)
    else $error("short erroneous frame not suppressed");
  start_err_a: assert property (@(posedge clk) disable iff (reset)
    first_bits_done && iso_a_106 && first_bits_err && !noise_frame_suppression_config[EMD_START_ERR]
    |=> !rx_start_irq)
    else $error("reception start despite errors in first bits");
  reserved_a: assert property (@(posedge clk) disable iff (reset)
    subcarrier_start_limit[7:5] == 3'h0 && auxiliary_rx_definition[6] == 1'b0
    && noise_frame_suppression_config[5:4] == 2'h0)
    else $error("reserved bit stored");
endmodule

// [tb/rfc_card_model.sv]
`timescale 1ns/1ps
// ==========================================
// Card side of the RF link, as seen by the receive framing logic.
module rfc_card_model (
  input  wire logic       clk,
  output      logic       frame_done,
  output      logic [7:0] frame_len,
  output      logic       frame_err,
  output      logic       crc_ok,
  output      logic       first_bits_done,
  output      logic       first_bits_err,
  output      logic       mask_receive_timer_expired,
  output      logic       subcarrier_det
);
  // All event lines start quiet.
  initial begin
    {frame_done, first_bits_done, mask_receive_timer_expired, subcarrier_det} = 4'h0;
    {frame_len, frame_err, first_bits_err, crc_ok} = 11'h000;
  end
  // One event of one cycle; k picks frame, first bits, mask timer, subcarrier.
  // Qualifiers are inverted afterwards so a stale value never looks valid.
  task automatic ev(input logic [3:0] k, input logic [7:0] len, input logic err, input logic ok);
    @(posedge clk);
    {frame_done, first_bits_done, mask_receive_timer_expired, subcarrier_det} <= k;
    {frame_len, frame_err, first_bits_err, crc_ok} <= {len, err, err, ok};
    @(posedge clk);
    {frame_done, first_bits_done, mask_receive_timer_expired, subcarrier_det} <= 4'h0;
    {frame_len, frame_err, first_bits_err, crc_ok} <= ~{len, err, err, ok};
  endtask
endmodule

// [tb/rx_framing_emd_config_tb.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; $display("Error at %0t: got %0h expected %0h", $time, a, e); end end
// ==========================================
// Register and receive event tests.
module rx_framing_emd_config_tb;
  import rfc_pkg::*;
  logic        clk, reset, hsel, hwrite, hreadyout, hresp, iso_a_106, iso_b_106, tx_reqa_wupa, anticoll_active;
  logic        crc_check_en, phase_clock_shift, frame_accept, frame_suppress, rx_error, rx_start_irq;
  logic        soft_error_irq, restart_irq, frame_done, frame_err, crc_ok, first_bits_done, first_bits_err;
  logic        mask_receive_timer_expired, subcarrier_det;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, stream_scf, stream_scp, field_on_count;
  logic [2:0]  hsize;
  logic [7:0]  frame_len;
  logic [3:0]  uid_bytes;
  logic [5:0]  seen;                       // Pulses seen after one event.
  logic [3:0]  uidx [3] = '{UID_BYTES_4, UID_BYTES_7, UID_BYTES_RSV};
  rfc_proto_t  proto;
  rfc_rx_sel_t rx_select;
  int          failures, total_checks;

  rfc_rx_framing uut (
    .clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .proto, .stream_scf, .stream_scp, .iso_a_106, .iso_b_106, .tx_reqa_wupa, .anticoll_active, .frame_done,
    .frame_len, .frame_err, .crc_ok, .first_bits_done, .first_bits_err, .mask_receive_timer_expired, .subcarrier_det,
    .crc_check_en, .uid_bytes, .phase_clock_shift, .rx_select, .field_on_count, .frame_accept, .frame_suppress,
    .rx_error, .rx_start_irq, .soft_error_irq, .restart_irq);
  rfc_card_model card (.clk, .frame_done, .frame_len, .frame_err, .crc_ok, .first_bits_done, .first_bits_err,
    .mask_receive_timer_expired, .subcarrier_det);

  // 10 MHz clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Holds the current phase until hready is sampled high at an edge; sampling
  // at the falling edge avoids racing the slave's own update.
  task automatic bus_wait;
    do @(negedge clk); while (hreadyout !== 1'b1);
    @(posedge clk);
  endtask
  // One single word transfer: address phase, then data phase.
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    {hsel, htrans, hwrite, hsize, haddr} <= {1'b1, 2'b10, w, 3'b010, 22'h0, idx, 2'b00};
    bus_wait;
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, 24'h0, d};
    bus_wait;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    `CHK({hresp, hrdata}, {1'b0, 24'h0, e})
  endtask
  // Lets a register write reach the decoded outputs.
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Sends one event and gathers every pulse in the two cycles after it.
  task automatic evt(input logic [3:0] k, input logic [7:0] len, input logic err, input logic ok,
                     input logic [5:0] e);
    card.ev(k, len, err, ok);
    seen = 6'h00;
    repeat (2) begin
      #1 seen |= {frame_accept, frame_suppress, rx_error, rx_start_irq, soft_error_irq, restart_irq};
      @(posedge clk);
    end
    `CHK(seen, e)
  endtask
  task automatic rxs(input rfc_proto_t p, input logic [3:0] sc, input logic sel, input rfc_rx_sel_t e);
    @(posedge clk);
    proto <= p;
    {stream_scf, stream_scp} <= sc;
    wr(AUX_IDX, {5'h00, sel, 2'h0});
    settle;
    `CHK(rx_select, e)
  endtask
  // Mask timer ends, then the subcarrier arrives n + 2 cycles later.
  task automatic sc(input int n, input logic [5:0] e);
    card.ev(4'h2, 8'h00, 1'b0, 1'b1);
    repeat (n) @(posedge clk);
    evt(4'h1, 8'h00, 1'b0, 1'b1, e);
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need.
  initial begin
    #3000000;
    failures++;
    tally_and_finish;
  end
  // Main sequence.
  initial begin
    {reset, hsel, hwrite, htrans, hsize, haddr, hwdata} = {1'b1, 1'b0, 1'b0, 2'b00, 3'b010, 64'h0};
    {iso_a_106, iso_b_106, tx_reqa_wupa, anticoll_active, stream_scf, stream_scp} = 8'h00;
    proto = PROTO_ISO_A;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    #1;
    `CHK({crc_check_en, uid_bytes, rx_select}, {1'b1, UID_BYTES_4, RX_NONE})
    rd(AUX_IDX, AUX_RST);
    rd(EMD_IDX, EMD_RST);
    rd(SST_IDX, SST_RST);
    wr(AUX_IDX, 8'hFF);
    rd(AUX_IDX, 8'hBF);
    settle;
    `CHK({crc_check_en, phase_clock_shift, field_on_count, uid_bytes}, {4'h7, UID_BYTES_RSV})
    wr(EMD_IDX, 8'hFF);
    rd(EMD_IDX, 8'hCF);
    wr(SST_IDX, 8'hFF);
    rd(SST_IDX, 8'h1F);
    wr(8'h0F, 8'hFF);
    rd(8'h0F, 8'h00);
    for (int u = 0; u < 3; u++) begin
      wr(AUX_IDX, {2'b00, u[1:0], 4'h0});
      settle;
      `CHK({uid_bytes, phase_clock_shift}, {uidx[u], 1'b0})
    end
    rxs(PROTO_ISO_A, 4'h0, 1'b0, RX_CORRELATOR);
    rxs(PROTO_ISO_A, 4'h0, 1'b1, RX_NONE);
    rxs(PROTO_ISO_B, 4'h0, 1'b1, RX_PULSE_COHERENT);
    rxs(PROTO_NFC_F, 4'h0, 1'b1, RX_PULSE);
    rxs(PROTO_T1T, 4'h0, 1'b0, RX_CORRELATOR);
    rxs(PROTO_STREAM, {SCF_CORR, SCP_CORR}, 1'b0, RX_CORRELATOR);
    rxs(PROTO_STREAM, 4'h0, 1'b1, RX_PULSE);
    rxs(PROTO_STREAM, 4'h0, 1'b0, RX_NONE);
    wr(AUX_IDX, 8'h00);
    wr(EMD_IDX, 8'h00);
    evt(4'h8, 8'h05, 1'b0, 1'b0, 6'h08);
    wr(AUX_IDX, 8'h80);
    evt(4'h8, 8'h05, 1'b0, 1'b0, 6'h20);
    wr(AUX_IDX, 8'h00);
    tx_reqa_wupa <= 1'b1;
    @(posedge clk);
    tx_reqa_wupa <= 1'b0;
    evt(4'h8, 8'h05, 1'b0, 1'b0, 6'h20);
    evt(4'h8, 8'h05, 1'b0, 1'b0, 6'h08);
    anticoll_active <= 1'b1;
    evt(4'h8, 8'h05, 1'b0, 1'b0, 6'h20);
    anticoll_active <= 1'b0;
    wr(EMD_IDX, 8'h84);
    evt(4'h8, 8'h03, 1'b1, 1'b1, 6'h10);
    evt(4'h8, 8'h04, 1'b1, 1'b1, 6'h08);
    wr(EMD_IDX, 8'h04);
    evt(4'h8, 8'h03, 1'b1, 1'b1, 6'h08);
    iso_a_106 <= 1'b1;
    evt(4'h4, 8'h00, 1'b1, 1'b1, 6'h00);
    evt(4'h4, 8'h00, 1'b0, 1'b1, 6'h04);
    wr(EMD_IDX, 8'h44);
    evt(4'h4, 8'h00, 1'b1, 1'b1, 6'h04);
    iso_a_106 <= 1'b0;
    iso_b_106 <= 1'b1;
    wr(SST_IDX, 8'h02);
    sc(5, 6'h02);
    sc(30, 6'h02);
    sc(60, 6'h00);
    wr(EMD_IDX, 8'h84);
    sc(5, 6'h01);
    rd(STAT_IDX, 8'h04);
    tally_and_finish;
  end
endmodule
